// file: phy_mgmt_pkg.sv
package phy_mgmt_pkg;

  localparam logic [4:0]  REG_GIG_STATUS    = 5'h0a;
  localparam logic [4:0]  REG_MMD_CTRL      = 5'h0d;
  localparam logic [4:0]  REG_MMD_ADDR_DATA = 5'h0e;
  localparam logic [4:0]  REG_GIG_ABILITY   = 5'h0f;
  localparam logic [4:0]  REG_PHY_CTRL      = 5'h10;

  localparam int          ST_FAULT_BIT      = 15;
  localparam int          ST_ROLE_BIT       = 14;
  localparam int          ST_LOC_RX_BIT     = 13;
  localparam int          ST_REM_RX_BIT     = 12;
  localparam int          ST_LP_FD_BIT      = 11;
  localparam int          ST_LP_HD_BIT      = 10;
  localparam int          ST_IDLE_W         = 8;

  localparam int          MC_FUNC_LSB       = 14;
  localparam int          MC_DEV_W          = 5;
  localparam logic [4:0]  MMD_VENDOR_DEV    = 5'h1f;

  localparam logic [15:0] ABILITY_VALUE     = 16'hf000;
  localparam logic [15:0] PHY_CTRL_RESET    = 16'h5048;
  localparam logic [15:0] PHY_CTRL_RW_MASK  = 16'hf773;
  localparam int          PC_TXF_LSB        = 14;
  localparam int          PC_RXF_LSB        = 12;
  localparam int          PC_FORCE_BIT      = 10;
  localparam int          PC_PS_LSB         = 8;
  localparam int          PC_XO_LSB         = 5;
  localparam int          PC_CLKOFF_BIT     = 4;
  localparam int          PC_LDI_BIT        = 1;
  localparam int          PC_JAB_BIT        = 0;

  localparam logic [5:0]  PREAMBLE_BITS     = 6'h20;
  localparam logic [3:0]  HDR_LAST          = 4'hc;
  localparam logic [3:0]  DATA_LAST         = 4'hf;
  localparam logic [1:0]  OP_READ           = 2'h2;
  localparam logic [1:0]  OP_WRITE          = 2'h1;

  typedef enum logic [1:0] {
    FUNC_ADDRESS    = 2'h0,
    FUNC_DATA       = 2'h1,
    FUNC_DATA_INC   = 2'h2,
    FUNC_DATA_INCWR = 2'h3
  } mmd_func_t;

  typedef enum logic [1:0] {
    PS_NORMAL   = 2'h0,
    PS_RESERVED = 2'h1,
    PS_ACTIVE   = 2'h2,
    PS_PASSIVE  = 2'h3
  } power_save_t;

  typedef enum logic [3:0] {
    ST_PRE = 4'b0001,
    ST_HDR = 4'b0010,
    ST_TA  = 4'b0100,
    ST_DAT = 4'b1000
  } frame_state_t;

  // fifo depth code to entries: 3, 4, 6, 8
  function automatic logic [3:0] fifo_depth_of(input logic [1:0] code);
    unique case (code)
      2'h0: fifo_depth_of = 4'h3;
      2'h1: fifo_depth_of = 4'h4;
      2'h2: fifo_depth_of = 4'h6;
      default: fifo_depth_of = 4'h8;
    endcase
  endfunction

endpackage

// file: pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit moves only once the second and third stage agree
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      level_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// file: mmd_port.sv
`timescale 1ns/1ps
module mmd_port
  import phy_mgmt_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    acc_wr,
  input  wire logic                    acc_rd,
  input  wire phy_mgmt_pkg::mmd_func_t func,
  input  wire logic [15:0]             wdata,
  output logic      [15:0]             addr_q,
  output logic      [15:0]             wdata_q,
  output logic                         wr_q,
  output logic                         rd_q
);
  logic inc_q;
  logic is_data;

  // function zero reaches the address, others the data
  assign is_data = (func != FUNC_ADDRESS);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      wdata_q <= 16'h0000;
    end else begin
      wr_q <= acc_wr && is_data;
      rd_q <= acc_rd && is_data;
      if (acc_wr && is_data) begin
        wdata_q <= wdata;
      end
    end
  end

  // increment after the strobe, so the strobe sees the old address
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      inc_q <= 1'b0;
    end else begin
      inc_q <= (acc_wr && (func == FUNC_DATA_INC || func == FUNC_DATA_INCWR))
            || (acc_rd && func == FUNC_DATA_INC);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_q <= 16'h0000;
    end else if (acc_wr && !is_data) begin
      addr_q <= wdata;
    end else if (inc_q) begin
      addr_q <= addr_q + 16'h0001;
    end
  end
endmodule

// file: phy_mgmt_regs.sv
`timescale 1ns/1ps
module phy_mgmt_regs
  import phy_mgmt_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic                      mdc,
  input  wire logic                      mdio_in,
  output logic                           mdio_out,
  output logic                           mdio_oe,
  input  wire logic [1:0]                strap_crossover,
  input  wire logic                      role_config_fault,
  input  wire logic                      role_resolution,
  input  wire logic                      local_receiver_ok,
  input  wire logic                      remote_receiver_ok,
  input  wire logic                      partner_gig_full_duplex,
  input  wire logic                      partner_gig_half_duplex,
  input  wire logic [7:0]                idle_err_count,
  input  wire logic                      link_up_raw,
  input  wire logic                      speed_is_gig,
  input  wire logic                      mac_is_gmii,
  input  wire logic                      mac_is_sgmii,
  input  wire logic                      mirror_mode,
  input  wire logic [15:0]               mmd_rdata,
  output logic      [4:0]                mmd_device_select,
  output logic      [15:0]               mmd_addr,
  output logic      [15:0]               mmd_wdata,
  output logic                           mmd_wr,
  output logic                           mmd_rd,
  output logic      [3:0]                tx_fifo_depth,
  output logic                           tx_fifo_active,
  output logic      [3:0]                rx_fifo_depth,
  output logic                           rx_fifo_active,
  output logic                           link_good,
  output phy_mgmt_pkg::power_save_t      power_save,
  output logic                           force_mdi,
  output logic                           force_mdix,
  output logic                           auto_crossover,
  output logic                           ref_output_clock_en,
  output logic                           line_driver_invert,
  output logic                           jabber_enable
);
  frame_state_t state_q;
  logic [1:0]   pins_q;
  logic         mdc_prev_q;
  logic         edge_s;
  logic         mdio_s;
  logic [5:0]   pre_cnt_q;
  logic [3:0]   bit_cnt_q;
  logic [11:0]  hdr_q;
  logic [12:0]  hdr_full;
  logic         hdr_end;
  logic         hdr_ok;
  logic         rd_take;
  logic         is_read_q;
  logic [4:0]   reg_q;
  logic [15:0]  sh_q;
  logic [15:0]  wr_val;
  logic         wr_done;
  logic [15:0]  rd_val;
  logic         fault_q;
  logic         fault_clr;
  mmd_func_t    func_q;
  logic [4:0]   mmd_device_select_q;
  logic [15:0]  ctrl_q;
  logic         strap_done_q;

  // mdc in bit 1, mdio in bit 0
  pin_sync3 #(
    .WIDTH (2)
  ) u_sync (
    .clock   (clock),
    .resetn  (resetn),
    .pin     ({mdc, mdio_in}),
    .level_q (pins_q)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= pins_q[1];
    end
  end

  assign edge_s   = pins_q[1] && !mdc_prev_q;
  assign mdio_s   = pins_q[0];
  assign hdr_full = {hdr_q, mdio_s};
  assign hdr_end  = edge_s && (state_q == ST_HDR) && (bit_cnt_q == HDR_LAST);
  assign hdr_ok   = hdr_full[12] && (hdr_full[9:5] == PHY_ADDR)
                 && (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);
  assign rd_take  = hdr_end && hdr_ok && (hdr_full[11:10] == OP_READ);
  assign wr_done  = edge_s && (state_q == ST_DAT) && (bit_cnt_q == DATA_LAST) && !is_read_q;
  assign wr_val   = {sh_q[14:0], mdio_s};

  // frame sequencer: preamble, start/op/address, turnaround, data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q   <= ST_PRE;
      bit_cnt_q <= 4'h0;
    end else if (edge_s) begin
      unique case (state_q)
        ST_PRE: begin
          bit_cnt_q <= 4'h0;
          if (!mdio_s && pre_cnt_q >= PREAMBLE_BITS) begin
            state_q <= ST_HDR;
          end
        end
        ST_HDR: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == HDR_LAST) begin
            bit_cnt_q <= 4'h0;
            state_q   <= hdr_ok ? ST_TA : ST_PRE;
          end
        end
        ST_TA: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == 4'h1) begin
            bit_cnt_q <= 4'h0;
            state_q   <= ST_DAT;
          end
        end
        ST_DAT: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == DATA_LAST) begin
            state_q <= ST_PRE;
          end
        end
      endcase
    end
  end

  // preamble suppression is not supported: every frame needs 32 ones
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_q <= 6'h00;
    end else if (edge_s) begin
      if (state_q != ST_PRE || !mdio_s) begin
        pre_cnt_q <= 6'h00;
      end else if (pre_cnt_q < PREAMBLE_BITS) begin
        pre_cnt_q <= pre_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hdr_q     <= 12'h000;
      is_read_q <= 1'b0;
      reg_q     <= 5'h00;
    end else if (edge_s && state_q == ST_HDR) begin
      hdr_q <= hdr_full[11:0];
      if (hdr_end) begin
        is_read_q <= (hdr_full[11:10] == OP_READ);
        reg_q     <= hdr_full[4:0];
      end
    end else if (edge_s && state_q == ST_PRE) begin
      hdr_q <= 12'h000;
    end
  end

  // read snapshot taken at the header end; unmapped registers read zero
  always_comb begin
    rd_val = 16'h0000;
    unique case (hdr_full[4:0])
      REG_GIG_STATUS: begin
        rd_val[ST_FAULT_BIT]     = fault_q;
        rd_val[ST_ROLE_BIT]      = role_resolution;
        rd_val[ST_LOC_RX_BIT]    = local_receiver_ok;
        rd_val[ST_REM_RX_BIT]    = remote_receiver_ok;
        rd_val[ST_LP_FD_BIT]     = partner_gig_full_duplex;
        rd_val[ST_LP_HD_BIT]     = partner_gig_half_duplex;
        rd_val[ST_IDLE_W-1:0]    = idle_err_count;
      end
      REG_MMD_CTRL: begin
        rd_val[MC_FUNC_LSB+:2]   = func_q;
        rd_val[MC_DEV_W-1:0]     = mmd_device_select_q;
      end
      REG_MMD_ADDR_DATA: rd_val  = (func_q == FUNC_ADDRESS) ? mmd_addr : mmd_rdata;
      REG_GIG_ABILITY:   rd_val  = ABILITY_VALUE;
      REG_PHY_CTRL:      rd_val  = ctrl_q;
      default:           rd_val  = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sh_q <= 16'h0000;
    end else if (rd_take) begin
      sh_q <= rd_val;
    end else if (edge_s && state_q == ST_DAT) begin
      sh_q <= is_read_q ? {sh_q[14:0], 1'b0} : wr_val;
    end
  end

  // turnaround: release for the first bit, drive zero for the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mdio_oe  <= 1'b0;
      mdio_out <= 1'b0;
    end else if (edge_s && is_read_q) begin
      if (state_q == ST_TA && bit_cnt_q == 4'h0) begin
        mdio_oe  <= 1'b1;
        mdio_out <= 1'b0;
      end else if (state_q == ST_TA) begin
        mdio_out <= sh_q[15];
      end else if (state_q == ST_DAT && bit_cnt_q == DATA_LAST) begin
        mdio_oe  <= 1'b0;
        mdio_out <= 1'b0;
      end else if (state_q == ST_DAT) begin
        mdio_out <= sh_q[14];
      end
    end
  end

  // latched fault, read clears, new event wins
  assign fault_clr = rd_take && (hdr_full[4:0] == REG_GIG_STATUS);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_q <= 1'b0;
    end else if (role_config_fault) begin
      fault_q <= 1'b1;
    end else if (fault_clr) begin
      fault_q <= 1'b0;
    end
  end

  // access control keeps only function and device fields
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      func_q  <= FUNC_ADDRESS;
      mmd_device_select_q <= 5'h00;
    end else if (wr_done && reg_q == REG_MMD_CTRL) begin
      func_q  <= mmd_func_t'(wr_val[MC_FUNC_LSB+:2]);
      mmd_device_select_q <= wr_val[MC_DEV_W-1:0];
    end
  end

  // reserved control bits keep their reset value
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q       <= PHY_CTRL_RESET;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (wr_done && reg_q == REG_PHY_CTRL) begin
        ctrl_q <= (wr_val & PHY_CTRL_RW_MASK) | (ctrl_q & ~PHY_CTRL_RW_MASK);
      end else if (!strap_done_q) begin
        ctrl_q[PC_XO_LSB+:2] <= strap_crossover;
      end
    end
  end

  mmd_port u_mmd (
    .clock   (clock),
    .resetn  (resetn),
    .acc_wr  (wr_done && reg_q == REG_MMD_ADDR_DATA),
    .acc_rd  (rd_take && hdr_full[4:0] == REG_MMD_ADDR_DATA),
    .func    (func_q),
    .wdata   (wr_val),
    .addr_q  (mmd_addr),
    .wdata_q (mmd_wdata),
    .wr_q    (mmd_wr),
    .rd_q    (mmd_rd)
  );

  // control outputs, all registered
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mmd_device_select   <= 5'h00;
      tx_fifo_depth       <= 4'h0;
      tx_fifo_active      <= 1'b0;
      rx_fifo_depth       <= 4'h0;
      rx_fifo_active      <= 1'b0;
      link_good           <= 1'b0;
      power_save          <= PS_NORMAL;
      force_mdi           <= 1'b0;
      force_mdix          <= 1'b0;
      auto_crossover      <= 1'b0;
      ref_output_clock_en <= 1'b0;
      line_driver_invert  <= 1'b0;
      jabber_enable       <= 1'b0;
    end else begin
      mmd_device_select   <= mmd_device_select_q;
      tx_fifo_depth       <= fifo_depth_of(ctrl_q[PC_TXF_LSB+:2]);
      tx_fifo_active      <= (mac_is_gmii && speed_is_gig) || mac_is_sgmii;
      rx_fifo_depth       <= fifo_depth_of(ctrl_q[PC_RXF_LSB+:2]);
      rx_fifo_active      <= mac_is_sgmii;
      link_good           <= link_up_raw || (ctrl_q[PC_FORCE_BIT] && speed_is_gig);
      power_save          <= power_save_t'(ctrl_q[PC_PS_LSB+:2]);
      force_mdi           <= (ctrl_q[PC_XO_LSB+:2] == 2'h0);
      force_mdix          <= (ctrl_q[PC_XO_LSB+:2] == 2'h1);
      auto_crossover      <= ctrl_q[PC_XO_LSB+1];
      ref_output_clock_en <= !ctrl_q[PC_CLKOFF_BIT];
      line_driver_invert  <= ctrl_q[PC_LDI_BIT] && !mirror_mode;
      jabber_enable       <= !ctrl_q[PC_JAB_BIT];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_FAULT_SET: assert property (role_config_fault |=> fault_q) else $error("fault event not latched");
  AST_FAULT_READ_CLEAR: assert property (fault_clr && !role_config_fault |=> !fault_q)
    else $error("fault not cleared by read");
  AST_STATUS_SNAPSHOT: assert property (fault_clr |=> sh_q[ST_ROLE_BIT] == $past(role_resolution)
    && sh_q[ST_IDLE_W-1:0] == $past(idle_err_count) && sh_q[9:8] == 2'h0)
    else $error("status snapshot wrong");
  AST_ABILITY_READ: assert property (rd_take && hdr_full[4:0] == REG_GIG_ABILITY |=> sh_q == 16'hf000)
    else $error("ability word wrong");
  AST_FORCE_LINK: assert property (ctrl_q[PC_FORCE_BIT] && speed_is_gig |=> link_good)
    else $error("forced link not good");
  AST_JABBER_OFF: assert property (ctrl_q[PC_JAB_BIT] |=> !jabber_enable) else $error("jabber still enabled");
  AST_MIRROR_NO_INVERT: assert property (mirror_mode |=> !line_driver_invert) else $error("mirror inverts");
  AST_TX_DEPTH_MIN: assert property (ctrl_q[PC_TXF_LSB+:2] == 2'h0 |=> tx_fifo_depth == 4'h3)
    else $error("transmit depth code zero not three");
  AST_POST_INCREMENT: assert property (wr_done && reg_q == REG_MMD_ADDR_DATA && func_q == FUNC_DATA_INCWR
    |=> mmd_wr ##1 mmd_addr == $past(mmd_addr, 2) + 16'h0001)
    else $error("address not incremented after write");
  AST_READ_TURNAROUND: assert property (rd_take |-> ##[1:200] (mdio_oe && !mdio_out))
    else $error("no turnaround drive after read header");

  COV_READ_FRAME: cover property (rd_take ##[1:400] (state_q == ST_PRE));
  COV_WRITE_CTRL: cover property (wr_done && reg_q == REG_PHY_CTRL);
  COV_FAULT_HELD: cover property (fault_q && fault_clr);
endmodule

// file: mdio_station.sv
`timescale 1ns/1ps
module mdio_station #(
  parameter int HALF = 20
) (
  input  wire logic clock,
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_level
);
  logic drive_q;
  logic bit_q;

  // nobody driving: the line floats to its pull-up level
  assign mdio_level = mdio_oe ? mdio_out : (drive_q ? bit_q : 1'b1);

  initial begin
    mdc = 1'b0;
    drive_q = 1'b0;
    bit_q = 1'b1;
  end

  // one whole frame; mdc rests low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [63:0] frame;
    frame = {32'hffff_ffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    ta = 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge clock);
      mdc <= 1'b0;
      // a read hands the line over once the register address is sent
      drive_q <= (op != 2'b10) || (i < 46);
      bit_q <= frame[63-i];
      repeat (HALF) @(posedge clock);
      if (i == 47) begin
        ta = mdio_level;
      end
      if (i >= 48) begin
        rd = {rd[14:0], mdio_level};
      end
      mdc <= 1'b1;
      repeat (HALF - 1) @(posedge clock);
    end
    @(posedge clock);
    mdc <= 1'b0;
    drive_q <= 1'b0;
    repeat (2 * HALF) @(posedge clock);
  endtask
endmodule

// file: phy_mgmt_status_control_regs_tb.sv
`timescale 1ns/1ps
module phy_mgmt_status_control_regs_tb;
  import phy_mgmt_pkg::*;
  localparam logic [4:0] PHY = 5'h03;
  localparam logic [3:0] DEPTH [4] = '{4'h3, 4'h4, 4'h6, 4'h8};
  logic        clock = 1'b0, resetn = 1'b0, mdc, mdio_in, mdio_out, mdio_oe;
  // strap differs from the nominal code so that a missed strap load shows
  logic [1:0]  strap_crossover = 2'h1;
  logic [5:0]  st = 6'h00;
  logic [7:0]  idle_err_count = 8'h00;
  logic        link_up_raw = 1'b0, speed_is_gig = 1'b1, mac_is_gmii = 1'b1, mac_is_sgmii = 1'b0;
  logic        mirror_mode = 1'b0, mmd_wr, mmd_rd, tx_fifo_active, rx_fifo_active, link_good;
  logic        force_mdi, force_mdix, auto_crossover, ref_output_clock_en, line_driver_invert;
  logic        jabber_enable, ta;
  logic [15:0] mmd_rdata, mmd_addr, mmd_wdata, last_wdata, rv, w;
  logic [4:0]  mmd_device_select;
  logic [3:0]  tx_fifo_depth, rx_fifo_depth;
  logic [1:0]  cv;
  power_save_t power_save;
  int          error_cnt = 0, cmp_count = 0, wr_cnt = 0, rd_cnt = 0;

  always #5 clock = ~clock;
  // extended register contents: a pattern tied to the address
  assign mmd_rdata = mmd_addr ^ 16'h5a5a;

  always @(posedge clock) begin
    if (mmd_wr === 1'b1) begin
      wr_cnt++;
      last_wdata = mmd_wdata;
    end
    if (mmd_rd === 1'b1) begin
      rd_cnt++;
    end
  end

  mdio_station u_mgr (.clock(clock), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_level(mdio_in));

  phy_mgmt_regs #(.PHY_ADDR(PHY)) dut (
    .clock(clock), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .strap_crossover(strap_crossover), .role_config_fault(st[0]), .role_resolution(st[5]),
    .local_receiver_ok(st[4]), .remote_receiver_ok(st[3]), .partner_gig_full_duplex(st[2]),
    .partner_gig_half_duplex(st[1]), .idle_err_count(idle_err_count), .link_up_raw(link_up_raw),
    .speed_is_gig(speed_is_gig), .mac_is_gmii(mac_is_gmii), .mac_is_sgmii(mac_is_sgmii),
    .mirror_mode(mirror_mode), .mmd_rdata(mmd_rdata), .mmd_device_select(mmd_device_select),
    .mmd_addr(mmd_addr), .mmd_wdata(mmd_wdata), .mmd_wr(mmd_wr), .mmd_rd(mmd_rd),
    .tx_fifo_depth(tx_fifo_depth), .tx_fifo_active(tx_fifo_active), .rx_fifo_depth(rx_fifo_depth),
    .rx_fifo_active(rx_fifo_active), .link_good(link_good), .power_save(power_save), .force_mdi(force_mdi),
    .force_mdix(force_mdix), .auto_crossover(auto_crossover), .ref_output_clock_en(ref_output_clock_en),
    .line_driver_invert(line_driver_invert), .jabber_enable(jabber_enable));

  // wide enough for the packed data, address and count compares
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] v);
    u_mgr.xfer(OP_WRITE, PHY, ra, v, rv, ta);
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    u_mgr.xfer(OP_READ, PHY, ra, 16'h0000, rv, ta);
    check(rv, exp);
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (99000) @(posedge clock);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    check({tx_fifo_depth, rx_fifo_depth}, 8'h44); // reset depth
    check({force_mdix, auto_crossover, jabber_enable}, 3'b101); // strap crossover
    rd_chk(REG_PHY_CTRL, (PHY_CTRL_RESET & ~16'h0060) | 16'h0020); // reset image
    rd_chk(REG_MMD_CTRL, 16'h0000); // reset value
    wr_reg(REG_GIG_ABILITY, 16'h0000);
    rd_chk(REG_GIG_ABILITY, ABILITY_VALUE); // fixed ability
    rd_chk(5'h05, 16'h0000); // unmapped read
    u_mgr.xfer(OP_READ, PHY + 5'h01, REG_GIG_ABILITY, 16'h0000, rv, ta);
    check({rv, ta}, 17'h1ffff); // foreign address idle
    idle_err_count <= 8'ha5;
    st <= 6'b110101;
    @(posedge clock);
    st[0] <= 1'b0;
    rd_chk(REG_GIG_STATUS, 16'he8a5); // fault latched
    check(ta, 1'b0); // turnaround zero
    idle_err_count <= 8'h5a;
    st <= 6'b001010;
    rd_chk(REG_GIG_STATUS, 16'h145a); // cleared by read
    for (int c = 0; c < 4; c++) begin
      cv = c[1:0];
      // reserved bits written as ones must not stick
      w = {cv, cv, 1'b1, cv[0], cv, 1'b1, cv, cv[1], 2'b11, cv[1], cv[0]};
      wr_reg(REG_PHY_CTRL, w);
      rd_chk(REG_PHY_CTRL, (w & PHY_CTRL_RW_MASK) | (PHY_CTRL_RESET & ~PHY_CTRL_RW_MASK)); // reserved kept
      check(tx_fifo_depth, DEPTH[c]); // depth code
      check(rx_fifo_depth, DEPTH[c]); // depth code
      check(power_save, cv); // save mode
      check({force_mdi, force_mdix, auto_crossover}, {cv == 2'h0, cv == 2'h1, cv[1]}); // crossover
      check(link_good, cv[0]); // forced link
      check(line_driver_invert, cv[1]); // invert
      check(jabber_enable, !cv[0]); // jabber off
      check(ref_output_clock_en, !cv[1]); // clock gate field
    end
    check({tx_fifo_active, rx_fifo_active}, 2'b10); // gmii at gig
    mirror_mode <= 1'b1;
    speed_is_gig <= 1'b0;
    repeat (3) @(posedge clock);
    check({line_driver_invert, link_good, tx_fifo_active}, 3'b000); // mirror and slow
    mac_is_sgmii <= 1'b1;
    repeat (3) @(posedge clock);
    check({tx_fifo_active, rx_fifo_active}, 2'b11); // sgmii on
    wr_reg(REG_MMD_CTRL, 16'h3fff); // vendor device
    rd_chk(REG_MMD_CTRL, 16'h001f); // reserved zero
    check(mmd_device_select, MMD_VENDOR_DEV); // routed device
    wr_reg(REG_MMD_ADDR_DATA, 16'h0123);
    check({mmd_addr, wr_cnt[3:0]}, 20'h01230); // address path
    rd_chk(REG_MMD_ADDR_DATA, 16'h0123); // address readback
    wr_reg(REG_MMD_CTRL, 16'h801f);
    wr_reg(REG_MMD_ADDR_DATA, 16'hbeef);
    check({last_wdata, mmd_addr, wr_cnt[3:0]}, 36'hbeef01241); // increment write
    rd_chk(REG_MMD_ADDR_DATA, 16'h0124 ^ 16'h5a5a); // data read
    check({mmd_addr, rd_cnt[3:0]}, 20'h01251); // increment read
    wr_reg(REG_MMD_CTRL, 16'hc01f);
    rd_chk(REG_MMD_ADDR_DATA, 16'h0125 ^ 16'h5a5a); // write only mode
    check({mmd_addr, rd_cnt[3:0]}, 20'h01252); // no read step
    wr_reg(REG_MMD_ADDR_DATA, 16'h1111);
    check({mmd_addr, wr_cnt[3:0]}, 20'h01262); // write step
    wr_reg(REG_MMD_CTRL, 16'h401f);
    wr_reg(REG_MMD_ADDR_DATA, 16'h2222);
    check({last_wdata, mmd_addr, wr_cnt[3:0]}, 36'h222201263); // plain data
    complete_run();
  end
endmodule
